/* hw/lv_pkg.sv */
package lv_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTRL = 16'hff50;
   localparam logic [15:0] IDX_LEVEL = 16'hff51;
   localparam logic [15:0] IDX_STATUS = 16'hff52;
   localparam logic [15:0] IDX_CLEAR = 16'hff53;
   localparam logic [15:0] IDX_ENABLE = 16'hff54;
   localparam logic [15:0] IDX_CAUSE = 16'hff55;
   localparam int IDX_W = 16;
   localparam int ADDR_LSB = 2;

   // detect_control_reg fields
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_FLAG_BIT = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // level_select_reg
   localparam int LEVEL_W = 4;
   localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
   localparam int LEVEL_COUNT = 10;

   // event bits, shared by status, clear and enable registers
   localparam int EV_W = 2;
   localparam int EV_RESET_BIT = 0;
   localparam int EV_LVI_BIT = 1;
   localparam logic [EV_W-1:0] EV_RST = 2'h0;

   // reset_cause_flags
   localparam int CAUSE_LV_BIT = 0;

   // software settling wait after enabling the comparator
   localparam int SETTLE_MIN_NS = 200000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETTLE_CYCLES = (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic enable;
      logic mode;
   } ctrl_reg_t;

   typedef struct packed {
      logic comp_en;
      logic [LEVEL_W-1:0] level_code;
   } analog_ctrl_t;
endpackage : lv_pkg

/* hw/lv_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module lv_sync2 (
   input wire logic i_clk,
   input wire logic i_clear,
   input wire logic i_d,
   output logic o_q
);
   logic meta_ff;
   logic sync_ff;

   // the first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (i_clear) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= i_d;
         sync_ff <= meta_ff;
      end
   end

   assign o_q = sync_ff;
endmodule : lv_sync2
`default_nettype wire

/* hw/lv_level_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module lv_level_decode #(
   parameter int LEVELS = lv_pkg::LEVEL_COUNT
) (
   input wire logic [lv_pkg::LEVEL_W-1:0] i_code,
   output logic o_valid
);
   import lv_pkg::*;

   generate
      if (LEVELS < 1 || LEVELS > (1 << LEVEL_W)) begin : g_bad
         $error("level count out of range");
      end
   endgenerate

   localparam logic [LEVEL_W:0] LIMIT = (LEVEL_W + 1)'(LEVELS);

   // codes beyond the table are prohibited and never arm the comparator
   assign o_valid = ({1'b0, i_code} < LIMIT);
endmodule : lv_level_decode
`default_nettype wire

/* hw/lv_detect_ctrl.sv */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lv_detect_ctrl #(
   parameter int PADDR_W = 32,
   parameter int LEVELS = lv_pkg::LEVEL_COUNT
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [PADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_below_threshold,
   output lv_pkg::analog_ctrl_t o_analog,
   output logic o_lv_reset,
   output logic o_lv_int_req,
   output logic o_irq
);
   import lv_pkg::*;

   generate
      if (PADDR_W < IDX_W + ADDR_LSB) begin : g_bad_addr
         $error("address bus too narrow for register map");
      end
      if (LEVELS < 1 || LEVELS > (1 << LEVEL_W)) begin : g_bad_levels
         $error("level count does not fit the level code");
      end
      if (EV_RESET_BIT >= EV_W || EV_LVI_BIT >= EV_W) begin : g_bad_events
         $error("event bit outside the status register");
      end
   endgenerate

   ctrl_reg_t ctrl_ff;
   logic [LEVEL_W-1:0] level_code_ff;
   logic low_voltage_flag_ff;
   logic lv_reset_ff;
   logic lv_reset_seen_ff;
   logic lv_int_req_ff;
   logic [EV_W-1:0] status_ff;
   logic [EV_W-1:0] nxt_status;
   logic [EV_W-1:0] irq_enable_ff;
   logic lv_cause_ff;
   logic irq_ff;
   analog_ctrl_t analog_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic nxt_slverr;

   logic own_reset;
   logic hard_reset;
   logic below_sync;
   logic level_valid;
   logic armed;
   logic lv_int_mask;
   logic access;
   logic done;
   logic wr_done;
   logic rd_done;
   logic addr_ok;
   logic [IDX_W-1:0] word_idx;
   logic hit_ctrl;
   logic hit_level;
   logic hit_status;
   logic hit_clear;
   logic hit_enable;
   logic hit_cause;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   logic [EV_W-1:0] ev_pending;
   logic nxt_irq;
   logic wr_ctrl;
   logic wr_level;
   logic wr_clear;
   logic wr_enable;
   logic rd_cause;

   // a reset that this block raised must not wipe the block's control and level setup; the interrupt enables still clear
   assign own_reset = i_reset & (lv_reset_ff | lv_reset_seen_ff);
   assign hard_reset = i_reset & ~own_reset;

   lv_sync2 u_sync (
      .i_clk(i_clk),
      .i_clear(hard_reset),
      .i_d(i_below_threshold),
      .o_q(below_sync)
   );

   lv_level_decode #(
      .LEVELS(LEVELS)
   ) u_decode (
      .i_code(level_code_ff),
      .o_valid(level_valid)
   );

   assign armed = ctrl_ff.enable & level_valid;
   assign lv_int_mask = ~irq_enable_ff[EV_LVI_BIT];

   // APB decode: one wait state, answer registered
   assign access = i_psel & i_penable;
   assign done = access & pready_ff;
   assign wr_done = done & i_pwrite;
   assign rd_done = done & ~i_pwrite;
   assign word_idx = i_paddr[ADDR_LSB +: IDX_W];
   assign addr_ok = (i_paddr[ADDR_LSB-1:0] == '0) && ((i_paddr >> (IDX_W + ADDR_LSB)) == '0);
   assign hit_ctrl = addr_ok && (word_idx == IDX_CTRL);
   assign hit_level = addr_ok && (word_idx == IDX_LEVEL);
   assign hit_status = addr_ok && (word_idx == IDX_STATUS);
   assign hit_clear = addr_ok && (word_idx == IDX_CLEAR);
   assign hit_enable = addr_ok && (word_idx == IDX_ENABLE);
   assign hit_cause = addr_ok && (word_idx == IDX_CAUSE);

   // one strobe per writable register plus the cause read, live only at the completing edge of a transfer
   // writes to read-only words are accepted and dropped
   assign wr_ctrl = wr_done & hit_ctrl;
   assign wr_level = wr_done & hit_level;
   assign wr_clear = wr_done & hit_clear;
   assign wr_enable = wr_done & hit_enable;
   assign rd_cause = rd_done & hit_cause;

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_slverr = 1'b0;
      if (hit_ctrl) begin
         nxt_prdata[CTRL_EN_BIT] = ctrl_ff.enable;
         nxt_prdata[CTRL_MODE_BIT] = ctrl_ff.mode;
         nxt_prdata[CTRL_FLAG_BIT] = low_voltage_flag_ff;
      end else if (hit_level) begin
         nxt_prdata[LEVEL_W-1:0] = level_code_ff;
      end else if (hit_status) begin
         nxt_prdata[EV_W-1:0] = status_ff;
      end else if (hit_enable) begin
         nxt_prdata[EV_W-1:0] = irq_enable_ff;
      end else if (hit_cause) begin
         nxt_prdata[CAUSE_LV_BIT] = lv_cause_ff;
      end else if (!hit_clear) begin
         nxt_slverr = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= access & ~pready_ff;
         if (access && !pready_ff) begin
            pslverr_ff <= nxt_slverr;
            prdata_ff <= i_pwrite ? 32'h0000_0000 : nxt_prdata;
         end else begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   // control register: bit 0 is read-only, 6..2 are ignored
   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         ctrl_ff.enable <= CTRL_RST[CTRL_EN_BIT];
         ctrl_ff.mode <= CTRL_RST[CTRL_MODE_BIT];
      end else if (!i_reset && wr_ctrl) begin
         ctrl_ff.enable <= i_pwdata[CTRL_EN_BIT];
         ctrl_ff.mode <= i_pwdata[CTRL_MODE_BIT];
      end
   end

   // a prohibited code stored while running simply disarms the comparator
   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         level_code_ff <= LEVEL_RST;
      end else if (!i_reset && wr_level) begin
         level_code_ff <= i_pwdata[LEVEL_W-1:0];
      end
   end

   // flag follows the comparator whatever the mode
   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         low_voltage_flag_ff <= 1'b0;
      end else begin
         low_voltage_flag_ff <= armed & below_sync;
      end
   end

   // reset output tracks the supply level; drops once supply recovers
   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         lv_reset_ff <= 1'b0;
      end else begin
         lv_reset_ff <= armed & ctrl_ff.mode & below_sync;
      end
   end

   // the system may stretch its reset past ours; remember who started it
   // without this a stretched reset would look external and wipe the setup
   always_ff @(posedge i_clk) begin
      if (!i_reset) begin
         lv_reset_seen_ff <= 1'b0;
      end else if (lv_reset_ff) begin
         lv_reset_seen_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         lv_int_req_ff <= 1'b0;
      end else begin
         lv_int_req_ff <= armed & ~ctrl_ff.mode & below_sync;
      end
   end

   // sticky events; set beats a same-cycle clear
   assign ev_set[EV_RESET_BIT] = lv_reset_ff;
   assign ev_set[EV_LVI_BIT] = lv_int_req_ff;
   assign ev_clr = wr_clear ? i_pwdata[EV_W-1:0] : '0;

   generate
      for (genvar i = 0; i < EV_W; i++) begin : g_event
         assign nxt_status[i] = ev_set[i] | (status_ff[i] & ~ev_clr[i]);
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         status_ff <= EV_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // every reset masks the detector interrupt
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_enable_ff <= EV_RST;
      end else if (wr_enable) begin
         irq_enable_ff <= i_pwdata[EV_W-1:0];
      end
   end

   // the detector request leaves only while its mask is clear, so enabling
   // the comparator unmasked can raise it at once; the reset event has its own enable
   assign ev_pending[EV_RESET_BIT] = status_ff[EV_RESET_BIT] & irq_enable_ff[EV_RESET_BIT];
   assign ev_pending[EV_LVI_BIT] = status_ff[EV_LVI_BIT] & ~lv_int_mask;
   assign nxt_irq = |ev_pending;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // cause bit survives our own reset, cleared by reading it
   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         lv_cause_ff <= 1'b0;
      end else if (lv_reset_ff) begin
         lv_cause_ff <= 1'b1;
      end else if (rd_cause) begin
         lv_cause_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (hard_reset) begin
         analog_ff <= '0;
      end else begin
         analog_ff.comp_en <= armed;
         analog_ff.level_code <= level_code_ff;
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_analog = analog_ff;
   assign o_lv_reset = lv_reset_ff;
   assign o_lv_int_req = lv_int_req_ff;
   assign o_irq = irq_ff;
endmodule : lv_detect_ctrl
`default_nettype wire

/* sim/lv_detect_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lv_detect_ctrl_assertions #(
   parameter int PADDR_W = 32,
   parameter int LEVELS = 10
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [PADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_below_threshold,
   input wire lv_pkg::analog_ctrl_t o_analog,
   input wire logic o_lv_reset,
   input wire logic o_lv_int_req,
   input wire logic o_irq
);
   import lv_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence setup_s;
      i_psel && !i_penable;
   endsequence
   sequence answer_s;
      !o_pready ##1 o_pready ##1 !o_pready;
   endsequence
   ready_timing_a: assert property (setup_s |=> answer_s)
      else $error("apb answer not after one wait state");
   ready_access_a: assert property (o_pready |-> i_psel && i_penable)
      else $error("pready outside access phase");
   err_with_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside answer cycle");
   reset_cause_a: assert property (o_lv_reset |-> $past(i_below_threshold, 3))
      else $error("lv reset without low supply");
   reset_release_a: assert property (o_lv_reset && !$past(i_below_threshold, 2) |=> !o_lv_reset)
      else $error("lv reset held after recovery");
   int_cause_a: assert property (o_lv_int_req |-> $past(i_below_threshold, 3))
      else $error("lv request without low supply");
   mode_excl_a: assert property (!(o_lv_reset && o_lv_int_req))
      else $error("reset and request together");
   level_valid_a: assert property (o_analog.comp_en |-> o_analog.level_code < LEVELS)
      else $error("comparator armed with bad code");
   quiet_disarmed_a: assert property (!o_analog.comp_en [*4] |-> !o_lv_int_req && !o_lv_reset)
      else $error("output while comparator disarmed");
endmodule : lv_detect_ctrl_assertions
bind lv_detect_ctrl lv_detect_ctrl_assertions #(.PADDR_W(PADDR_W), .LEVELS(LEVELS)) i_chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_below_threshold(i_below_threshold), .o_analog(o_analog),
   .o_lv_reset(o_lv_reset), .o_lv_int_req(o_lv_int_req), .o_irq(o_irq));
`default_nettype wire

/* sim/tb_lv_detect_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_lv_detect_ctrl;
   import lv_pkg::*;
   logic clk, reset, psel, penable, pwrite, below, pready, pslverr, lv_reset, lv_int_req, irq;
   logic [31:0] paddr, pwdata, prdata;
   analog_ctrl_t analog;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [3:0] lvl;
   int fails, check_count;
   lv_detect_ctrl i_dut (.i_clk(clk), .i_reset(reset), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_below_threshold(below), .o_analog(analog), .o_lv_reset(lv_reset),
      .o_lv_int_req(lv_int_req), .o_irq(irq));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // expectation word: {compare data, expected pslverr, expected data}
   task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic [33:0] ex);
      q.push_back(ex);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no cycle count assumed; only the watchdog ends a stuck wait
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [15:0] idx, input logic [31:0] ex);
      xfer(1'b0, idx, 32'h0, {2'b10, ex});
   endtask : rd
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d, {2'b00, 32'h0});
   endtask : wr
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // comparator path is three edges, status and irq two more
   task automatic drv(input logic b);
      @(posedge clk);
      below <= b;
      tick(6);
   endtask : drv
   task automatic hold_reset(input int n);
      @(posedge clk);
      reset <= 1'b1;
      below <= 1'b0;
      repeat (n) @(posedge clk);
      reset <= 1'b0;
   endtask : hold_reset
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         e = q.pop_front();
         if (e[33]) begin
            chk("prdata", e[31:0], prdata);
         end
         chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      end
   end
   initial begin
      // two settle waits dominate; 4000 more cycles cover a few hundred bus cycles
      #(40 * (2 * SETTLE_CYCLES + 4000));
      fails++;
      print_verdict();
   end
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      below = 1'b0;
      fails = 0;
      check_count = 0;
      void'($urandom(1289));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(IDX_CTRL, 32'h0);
      rd(IDX_LEVEL, 32'h0);
      rd(IDX_ENABLE, 32'h0);
      rd(IDX_STATUS, 32'h0);
      rd(IDX_CAUSE, 32'h0);
      xfer(1'b0, 16'hff60, 32'h0, {2'b11, 32'h0});
      lvl = 4'($urandom_range(9, 0));
      wr(IDX_LEVEL, {28'h0, lvl});
      wr(IDX_CTRL, 32'h80);
      tick(2);
      chk("analog", {27'h0, 1'b1, lvl}, 32'(analog));
      tick(SETTLE_CYCLES);
      rd(IDX_CTRL, 32'h80);
      drv(1'b1);
      chk("lv_int_req", 32'h1, 32'(lv_int_req));
      chk("irq masked", 32'h0, 32'(irq));
      rd(IDX_CTRL, 32'h81);
      rd(IDX_STATUS, 32'h2);
      wr(IDX_ENABLE, 32'h2);
      tick(3);
      chk("irq", 32'h1, 32'(irq));
      drv(1'b0);
      chk("lv_int_req", 32'h0, 32'(lv_int_req));
      chk("irq sticky", 32'h1, 32'(irq));
      rd(IDX_CTRL, 32'h80);
      wr(IDX_CLEAR, 32'h2);
      tick(3);
      chk("irq", 32'h0, 32'(irq));
      wr(IDX_CTRL, 32'h0);
      wr(IDX_LEVEL, 32'hc);
      wr(IDX_CTRL, 32'h80);
      drv(1'b1);
      chk("disarmed", 32'h18, 32'({analog, lv_int_req}));
      wr(IDX_CTRL, 32'h0);
      drv(1'b0);
      wr(IDX_LEVEL, 32'h3);
      wr(IDX_CTRL, 32'h80);
      tick(SETTLE_CYCLES);
      rd(IDX_CTRL, 32'h80);
      wr(IDX_CTRL, 32'h82);
      tick(4);
      chk("no reset", 32'h0, 32'(lv_reset));
      for (int i = 0; i < 2; i++) begin
         drv(1'b1);
         chk("lv_reset", 32'h1, 32'(lv_reset));
         drv(1'b0);
         chk("lv_reset", 32'h0, 32'(lv_reset));
      end
      drv(1'b1);
      hold_reset(6);
      rd(IDX_CTRL, 32'h82);
      rd(IDX_LEVEL, 32'h3);
      rd(IDX_ENABLE, 32'h0);
      rd(IDX_CAUSE, 32'h1);
      rd(IDX_CAUSE, 32'h0);
      rd(IDX_STATUS, 32'h1);
      wr(IDX_CTRL, 32'h80);
      wr(IDX_CTRL, 32'h0);
      drv(1'b1);
      chk("stopped", 32'h0, 32'(lv_reset));
      hold_reset(2);
      rd(IDX_CTRL, 32'h0);
      rd(IDX_LEVEL, 32'h0);
      rd(IDX_CAUSE, 32'h0);
      print_verdict();
   end
endmodule : tb_lv_detect_ctrl
`default_nettype wire
